// *** common/flash_seq_map.svh ***
// offsets, field positions, reset values and timing counts of the flash self-write sequencer
`ifndef FLASH_SEQ_MAP_SVH
`define FLASH_SEQ_MAP_SVH
`define OFF_CTRL      3'h0
`define OFF_UNLOCK    3'h1
`define OFF_ADDR_LO   3'h2
`define OFF_ADDR_HI   3'h3
`define OFF_DATA_LO   3'h4
`define OFF_DATA_HI   3'h5
`define CTRL_RD_BIT   0
`define CTRL_WR_BIT   1
`define CTRL_WRITE_ENABLE_BIT_BIT 2
`define CTRL_TEST_BIT 6
`define CTRL_RESET    1'b0
`define REG_RESET     8'h00
`define SYNC_RESET    4'h4
`define UNLOCK_KEY1   8'h55
`define UNLOCK_KEY2   8'hAA
`define SLOT_LAST     2'h3
`define ROW_FIRST     4'h3
`define WP_LIM_NONE   13'h0000
`define WP_LIM_LOW    13'h0100
`define WP_LIM_HALF   13'h0800
`define WP_LIM_ALL    13'h1000
`define PREP_CYCLES   2
`define CLK_KHZ       50000
`define STALL_MS      4
`define PWRT_MS       72
`define STALL_CYCLES  (`STALL_MS * `CLK_KHZ)
`define PWRT_CYCLES   (`PWRT_MS * `CLK_KHZ)
`endif

// *** common/flash_seq_pkg.sv ***
// types of the flash self-write sequencer
package flash_seq_pkg;
	typedef logic [13:0] word_t;
	typedef logic [11:0] addr_t;
	typedef enum logic [2:0] {
		UNL_IDLE  = 3'h1,
		UNL_KEY1  = 3'h2,
		UNL_ARMED = 3'h4
	} unlock_e;
	typedef enum logic [4:0] {
		S_IDLE  = 5'h01,
		S_PREP  = 5'h02,
		S_ERASE = 5'h04,
		S_PROG  = 5'h08,
		S_WAIT  = 5'h10
	} seq_e;
endpackage

// *** src/flash_self_write_sequencer.sv ***
// flash self-write sequencer: unlock, four-word buffer, row erase, program and stall
//
// Contract
// - self-write only into unprotected segments
// - serial port: code protect blocks, not write-protect
// - writes go in aligned four-word groups
// - operation is row erase plus aligned group
// - trigger on slot 11 commits buffer
// - two preparation cycles after every trigger
// - first three slots load without stall
// - processor halts about 4 ms, clocks run
// - execution resumes when halt drops
// - erase only when low nibble is 0011
// - reset clears write enable
// - no writes during 72 ms power-up timer
// - code protect disables test area reads
// - write protect never blocks reads
// - trigger set-only, cleared by hardware
// - write enable low inhibits all writes
// - read trigger fetches word, clears itself
// - high address register gives top 4 bits
`timescale 1ns/1ps
`include "flash_seq_map.svh"
module flash_self_write_sequencer #(
	parameter int unsigned STALL_CYCLES = `STALL_CYCLES,
	parameter int unsigned PWRT_CYCLES  = `PWRT_CYCLES
) (
	// clock, reset, enable
	input  wire logic                 clk_in,
	input  wire logic                 resetn_in,
	input  wire logic                 ce_in,
	// register port
	input  wire logic [2:0]           reg_addr_in,
	input  wire logic [7:0]           reg_wdata_in,
	input  wire logic                 reg_wr_in,
	input  wire logic                 reg_rd_in,
	output logic      [7:0]           reg_rdata_out,
	// configuration pins
	input  wire logic [1:0]           write_protect_field_in,
	input  wire logic                 code_protect_in,
	// external serial programming request
	input  wire logic                 ext_prog_write_in,
	output logic                      ext_prog_allow_out,
	// program memory array
	output flash_seq_pkg::addr_t      flash_addr_out,
	output flash_seq_pkg::word_t      flash_wdata_out,
	input  wire flash_seq_pkg::word_t flash_rdata_in,
	output logic                      flash_rd_out,
	output logic                      flash_erase_out,
	output logic                      flash_prog_out,
	output logic                      flash_test_sel_out,
	// processor
	output logic                      cpu_halt_during_access_out
);
	////////////////////////////////////////////////////////////////////////
	// addresses below the limit are protected
	function automatic logic is_protected(input logic [1:0] field, input flash_seq_pkg::addr_t a);
		logic [12:0] lim;
		lim = `WP_LIM_NONE;
		case (field)
			2'h3: lim = `WP_LIM_NONE;
			2'h2: lim = `WP_LIM_LOW;
			2'h1: lim = `WP_LIM_HALF;
			default: lim = `WP_LIM_ALL;
		endcase
		is_protected = ({1'b0, a} < lim);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// configuration and pin synchronisers; reset state assumes full protection
	logic [3:0] sync1_ff;
	logic [3:0] sync2_ff;
	logic [1:0] wp_field;
	logic       cp_on;
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sync1_ff <= `SYNC_RESET;
			sync2_ff <= `SYNC_RESET;
		end else if (ce_in) begin
			sync1_ff <= {ext_prog_write_in, code_protect_in, write_protect_field_in};
			sync2_ff <= sync1_ff;
		end
	end
	assign wp_field = sync2_ff[1:0];
	assign cp_on    = sync2_ff[2];
	assign ext_prog_allow_out = sync2_ff[3] && !cp_on;

	////////////////////////////////////////////////////////////////////////
	// power-up timer
	logic [21:0] pwrt_cnt_ff;
	logic        pwrt_done_ff;
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pwrt_cnt_ff  <= 22'h0;
			pwrt_done_ff <= 1'b0;
		end else if (ce_in && !pwrt_done_ff) begin
			pwrt_cnt_ff <= pwrt_cnt_ff + 22'h1;
			if (pwrt_cnt_ff == 22'(PWRT_CYCLES - 1))
				pwrt_done_ff <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register decode and unlock sequence
	flash_seq_pkg::unlock_e unlock_ff;
	flash_seq_pkg::seq_e    seq_ff;
	logic                   wr_ctrl;
	logic                   wr_unlock;
	logic                   trig_ok;
	logic                   rd_go;
	logic                   seq_end;
	logic                   write_enable_bit_ff;
	logic                   test_ff;
	logic                   wr_ff;
	logic                   rd_ff;
	logic [7:0]             addr_lo_ff;
	logic [3:0]             addr_hi_ff;
	logic [7:0]             data_lo_ff;
	logic [5:0]             data_hi_ff;
	flash_seq_pkg::addr_t   cur_addr;

	assign wr_ctrl   = ce_in && reg_wr_in && (reg_addr_in == `OFF_CTRL);
	assign wr_unlock = ce_in && reg_wr_in && (reg_addr_in == `OFF_UNLOCK);
	assign cur_addr  = {addr_hi_ff, addr_lo_ff};
	assign rd_go     = wr_ctrl && reg_wdata_in[`CTRL_RD_BIT] && (seq_ff == flash_seq_pkg::S_IDLE);
	assign trig_ok   = wr_ctrl && reg_wdata_in[`CTRL_WR_BIT] && !wr_ff && write_enable_bit_ff
	                   && (unlock_ff == flash_seq_pkg::UNL_ARMED) && pwrt_done_ff
	                   && (seq_ff == flash_seq_pkg::S_IDLE) && !is_protected(wp_field, cur_addr);

	// any other write breaks the sequence, so the trigger must follow the keys directly
	// key sequence tracking
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in)
			unlock_ff <= flash_seq_pkg::UNL_IDLE;
		else if (ce_in && reg_wr_in) begin
			case (unlock_ff)
				flash_seq_pkg::UNL_KEY1:
					unlock_ff <= (wr_unlock && reg_wdata_in == `UNLOCK_KEY2) ?
					             flash_seq_pkg::UNL_ARMED : flash_seq_pkg::UNL_IDLE;
				default:
					unlock_ff <= (wr_unlock && reg_wdata_in == `UNLOCK_KEY1) ?
					             flash_seq_pkg::UNL_KEY1 : flash_seq_pkg::UNL_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control register
	// write enable cleared at reset
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			write_enable_bit_ff <= `CTRL_RESET;
			test_ff <= `CTRL_RESET;
		end else if (wr_ctrl) begin
			write_enable_bit_ff <= reg_wdata_in[`CTRL_WRITE_ENABLE_BIT_BIT];
			test_ff <= reg_wdata_in[`CTRL_TEST_BIT];
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in)
			wr_ff <= `CTRL_RESET;
		else if (ce_in) begin
			if (trig_ok)
				wr_ff <= 1'b1;
			else if (seq_end)
				wr_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in)
			rd_ff <= `CTRL_RESET;
		else if (ce_in)
			rd_ff <= rd_go;
	end

	////////////////////////////////////////////////////////////////////////
	// address and data registers; a fetched word overrides a software write
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			addr_lo_ff <= `REG_RESET;
			addr_hi_ff <= 4'h0;
		end else if (ce_in && reg_wr_in) begin
			if (reg_addr_in == `OFF_ADDR_LO)
				addr_lo_ff <= reg_wdata_in;
			if (reg_addr_in == `OFF_ADDR_HI)
				addr_hi_ff <= reg_wdata_in[3:0];
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			data_lo_ff <= `REG_RESET;
			data_hi_ff <= 6'h0;
		end else if (ce_in) begin
			if (rd_ff) begin
				data_lo_ff <= flash_rdata_in[7:0];
				data_hi_ff <= flash_rdata_in[13:8];
			end else if (reg_wr_in && reg_addr_in == `OFF_DATA_LO)
				data_lo_ff <= reg_wdata_in;
			else if (reg_wr_in && reg_addr_in == `OFF_DATA_HI)
				data_hi_ff <= reg_wdata_in[5:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// four-word buffer
	flash_seq_pkg::word_t buf_ff [4];
	for (genvar g = 0; g < 4; g++) begin : g_slot
		// slot chosen by low address bits
		always_ff @(posedge clk_in or negedge resetn_in) begin
			if (!resetn_in)
				buf_ff[g] <= 14'h0;
			else if (trig_ok && addr_lo_ff[1:0] == 2'(g))
				buf_ff[g] <= {data_hi_ff, data_lo_ff};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// erase and program sequencer
	logic [1:0]  cnt_ff;
	logic [1:0]  idx_ff;
	logic        commit_ff;
	logic        erase_req_ff;
	logic [9:0]  base_ff;
	logic [17:0] stall_ff;

	assign seq_end = ((seq_ff == flash_seq_pkg::S_PREP) && !commit_ff
	                  && cnt_ff == 2'(`PREP_CYCLES - 1))
	                 || ((seq_ff == flash_seq_pkg::S_WAIT)
	                  && stall_ff >= 18'(STALL_CYCLES - 1));

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			seq_ff       <= flash_seq_pkg::S_IDLE;
			cnt_ff       <= 2'h0;
			idx_ff       <= 2'h0;
			commit_ff    <= 1'b0;
			erase_req_ff <= 1'b0;
			base_ff      <= 10'h0;
			stall_ff     <= 18'h0;
		end else if (ce_in) begin
			case (seq_ff)
				flash_seq_pkg::S_IDLE: begin
					cnt_ff   <= 2'h0;
					idx_ff   <= 2'h0;
					stall_ff <= 18'h0;
					if (trig_ok) begin
						seq_ff       <= flash_seq_pkg::S_PREP;
						commit_ff    <= (addr_lo_ff[1:0] == `SLOT_LAST);
						erase_req_ff <= (addr_lo_ff[3:0] == `ROW_FIRST);
						base_ff      <= cur_addr[11:2];
					end
				end
				flash_seq_pkg::S_PREP: begin
					cnt_ff <= cnt_ff + 2'h1;
					if (cnt_ff == 2'(`PREP_CYCLES - 1)) begin
						if (!commit_ff)
							seq_ff <= flash_seq_pkg::S_IDLE;
						else if (erase_req_ff)
							seq_ff <= flash_seq_pkg::S_ERASE;
						else
							seq_ff <= flash_seq_pkg::S_PROG;
					end
				end
				flash_seq_pkg::S_ERASE: begin
					stall_ff <= stall_ff + 18'h1;
					seq_ff   <= flash_seq_pkg::S_PROG;
				end
				flash_seq_pkg::S_PROG: begin
					stall_ff <= stall_ff + 18'h1;
					idx_ff   <= idx_ff + 2'h1;
					if (idx_ff == `SLOT_LAST)
						seq_ff <= flash_seq_pkg::S_WAIT;
				end
				flash_seq_pkg::S_WAIT: begin
					stall_ff <= stall_ff + 18'h1;
					if (seq_end)
						seq_ff <= flash_seq_pkg::S_IDLE;
				end
				default: seq_ff <= flash_seq_pkg::S_IDLE;
			endcase
		end
	end

	// halting the core, not gating clocks, keeps peripherals running
	assign cpu_halt_during_access_out = (seq_ff == flash_seq_pkg::S_ERASE)
	                                    || (seq_ff == flash_seq_pkg::S_PROG)
	                                    || (seq_ff == flash_seq_pkg::S_WAIT);
	assign flash_rd_out       = rd_ff;
	// test area off under code protect
	assign flash_test_sel_out = test_ff && !cp_on;

	////////////////////////////////////////////////////////////////////////
	// array strobes, one cycle behind the sequencer state
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			flash_addr_out  <= 12'h0;
			flash_wdata_out <= 14'h0;
			flash_erase_out <= 1'b0;
			flash_prog_out  <= 1'b0;
		end else if (ce_in) begin
			flash_erase_out <= (seq_ff == flash_seq_pkg::S_ERASE);
			flash_prog_out  <= (seq_ff == flash_seq_pkg::S_PROG);
			flash_wdata_out <= buf_ff[idx_ff];
			if (rd_go)
				flash_addr_out <= cur_addr;
			else if (seq_ff == flash_seq_pkg::S_ERASE || seq_ff == flash_seq_pkg::S_PROG)
				flash_addr_out <= {base_ff, idx_ff};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register read port, data valid only in the cycle after the strobe
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in)
			reg_rdata_out <= `REG_RESET;
		else if (ce_in) begin
			reg_rdata_out <= `REG_RESET;
			if (reg_rd_in) begin
				case (reg_addr_in)
					`OFF_CTRL:    reg_rdata_out <= {1'b0, test_ff, 3'h0, write_enable_bit_ff, wr_ff, rd_ff};
					`OFF_ADDR_LO: reg_rdata_out <= addr_lo_ff;
					`OFF_ADDR_HI: reg_rdata_out <= {4'h0, addr_hi_ff};
					`OFF_DATA_LO: reg_rdata_out <= data_lo_ff;
					`OFF_DATA_HI: reg_rdata_out <= {2'h0, data_hi_ff};
					default:      reg_rdata_out <= `REG_RESET;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	property p_unlock_needed;
		@(posedge clk_in) disable iff (!resetn_in || !ce_in)
		(wr_ctrl && reg_wdata_in[`CTRL_WR_BIT] && seq_ff == flash_seq_pkg::S_IDLE
		 && unlock_ff != flash_seq_pkg::UNL_ARMED) |=> (seq_ff == flash_seq_pkg::S_IDLE && !wr_ff);
	endproperty
	a_unlock_needed: assert property (p_unlock_needed)
		else $error("trigger without unlock");

	property p_write_enable_bit_reset;
		@(posedge clk_in) $rose(resetn_in) |-> !write_enable_bit_ff;
	endproperty
	a_write_enable_bit_reset: assert property (p_write_enable_bit_reset)
		else $error("write enable set after reset");

	property p_pwrt_block;
		@(posedge clk_in) disable iff (!resetn_in)
		!pwrt_done_ff |-> (seq_ff == flash_seq_pkg::S_IDLE && !wr_ff);
	endproperty
	a_pwrt_block: assert property (p_pwrt_block)
		else $error("write during power-up timer");

	property p_protect;
		@(posedge clk_in) disable iff (!resetn_in || !ce_in)
		flash_prog_out |-> !is_protected(wp_field, flash_addr_out);
	endproperty
	a_protect: assert property (p_protect)
		else $error("programmed protected word");

	property p_load_only;
		@(posedge clk_in) disable iff (!resetn_in || !ce_in)
		(trig_ok && addr_lo_ff[1:0] != `SLOT_LAST) |=>
		(seq_ff == flash_seq_pkg::S_PREP && !cpu_halt_during_access_out) [*2]
		##1 (seq_ff == flash_seq_pkg::S_IDLE && !wr_ff && !flash_prog_out);
	endproperty
	a_load_only: assert property (p_load_only)
		else $error("buffer load misbehaved");

	property p_erase_commit;
		@(posedge clk_in) disable iff (!resetn_in || !ce_in)
		(trig_ok && addr_lo_ff[3:0] == `ROW_FIRST) |=> ##3 flash_erase_out ##1 flash_prog_out [*4];
	endproperty
	a_erase_commit: assert property (p_erase_commit)
		else $error("row erase commit wrong");

	property p_no_erase;
		@(posedge clk_in) disable iff (!resetn_in || !ce_in)
		(trig_ok && addr_lo_ff[1:0] == `SLOT_LAST && addr_lo_ff[3:2] != 2'h0) |=>
		##3 (!flash_erase_out && flash_prog_out) [*4];
	endproperty
	a_no_erase: assert property (p_no_erase)
		else $error("commit without erase wrong");

	property p_group_walk;
		@(posedge clk_in) disable iff (!resetn_in || !ce_in)
		$rose(flash_prog_out) |-> flash_addr_out[1:0] == 2'h0
		##1 (flash_addr_out[1:0] == 2'h1 && $stable(flash_addr_out[11:2]))
		##1 (flash_addr_out[1:0] == 2'h2 && $stable(flash_addr_out[11:2]))
		##1 (flash_addr_out[1:0] == 2'h3 && $stable(flash_addr_out[11:2]));
	endproperty
	a_group_walk: assert property (p_group_walk)
		else $error("group walk out of order");

	property p_stall_len;
		@(posedge clk_in) disable iff (!resetn_in || !ce_in)
		$rose(cpu_halt_during_access_out) |-> cpu_halt_during_access_out [*8];
	endproperty
	a_stall_len: assert property (p_stall_len)
		else $error("stall too short");

	property p_resume;
		@(posedge clk_in) disable iff (!resetn_in || !ce_in)
		$fell(cpu_halt_during_access_out) |-> (!wr_ff && seq_ff == flash_seq_pkg::S_IDLE);
	endproperty
	a_resume: assert property (p_resume)
		else $error("trigger not cleared at resume");

	property p_read;
		@(posedge clk_in) disable iff (!resetn_in || !ce_in)
		rd_go |=> (flash_rd_out && flash_addr_out == $past(cur_addr)) ##1 !flash_rd_out;
	endproperty
	a_read: assert property (p_read)
		else $error("read trigger misbehaved");

	property p_test_gate;
		@(posedge clk_in) disable iff (!resetn_in || !ce_in)
		(flash_test_sel_out || ext_prog_allow_out) |-> !$past(code_protect_in, 2);
	endproperty
	a_test_gate: assert property (p_test_gate)
		else $error("access allowed under code protect");

	c_erase: cover property (@(posedge clk_in) disable iff (!resetn_in) $rose(flash_erase_out));
	c_load: cover property (@(posedge clk_in) disable iff (!resetn_in)
		trig_ok && addr_lo_ff[1:0] == 2'h0);
	c_resume: cover property (@(posedge clk_in) disable iff (!resetn_in)
		$fell(cpu_halt_during_access_out));
	c_read: cover property (@(posedge clk_in) disable iff (!resetn_in) flash_rd_out);
endmodule

// *** verif/test_flash_self_write_sequencer.sv ***
// self-checking testbench of the flash self-write sequencer
`timescale 1ns/1ps
module test_flash_self_write_sequencer;
	localparam int STALL = 20;
	localparam int PWRT  = 64;
	logic                 clk_in;
	logic                 resetn_in;
	logic                 ce_in;
	logic [2:0]           reg_addr_in;
	logic [7:0]           reg_wdata_in;
	logic                 reg_wr_in;
	logic                 reg_rd_in;
	logic [7:0]           reg_rdata_out;
	logic [1:0]           write_protect_field_in;
	logic                 code_protect_in;
	logic                 ext_prog_write_in;
	logic                 ext_prog_allow_out;
	flash_seq_pkg::addr_t flash_addr_out;
	flash_seq_pkg::word_t flash_wdata_out;
	flash_seq_pkg::word_t flash_rdata_in;
	logic                 flash_rd_out;
	logic                 flash_erase_out;
	logic                 flash_prog_out;
	logic                 flash_test_sel_out;
	logic                 cpu_halt_during_access_out;
	int                   n_mismatch;
	int                   tests_run;
	int                   n_er;
	int                   n_pr;
	int                   n_halt;
	int                   n_rd;
	flash_seq_pkg::addr_t er_a;
	flash_seq_pkg::addr_t rd_a;
	flash_seq_pkg::addr_t pr_a [4];
	flash_seq_pkg::word_t pr_d [4];

	flash_self_write_sequencer #(.STALL_CYCLES(STALL), .PWRT_CYCLES(PWRT)) dut (
		.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
		.write_protect_field_in(write_protect_field_in), .code_protect_in(code_protect_in),
		.ext_prog_write_in(ext_prog_write_in), .ext_prog_allow_out(ext_prog_allow_out),
		.flash_addr_out(flash_addr_out), .flash_wdata_out(flash_wdata_out),
		.flash_rdata_in(flash_rdata_in), .flash_rd_out(flash_rd_out),
		.flash_erase_out(flash_erase_out), .flash_prog_out(flash_prog_out),
		.flash_test_sel_out(flash_test_sel_out),
		.cpu_halt_during_access_out(cpu_halt_during_access_out));

	////////////////////////////////////////////////////////////////////////////////
	// array contents differ from any data the bench loads, so a stale word shows
	function automatic flash_seq_pkg::word_t pat(input flash_seq_pkg::addr_t a);
		return {2'h2, a ^ 12'hA5C};
	endfunction
	assign flash_rdata_in = pat(flash_addr_out);

	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end

	always @(posedge clk_in) begin
		if (flash_erase_out === 1'b1) begin
			n_er++;
			er_a = flash_addr_out;
		end
		if (flash_prog_out === 1'b1) begin
			if (n_pr < 4) begin
				pr_a[n_pr] = flash_addr_out;
				pr_d[n_pr] = flash_wdata_out;
			end
			n_pr++;
		end
		if (flash_rd_out === 1'b1) begin
			n_rd++;
			rd_a = flash_addr_out;
		end
		if (cpu_halt_during_access_out === 1'b1) n_halt++;
	end

	////////////////////////////////////////////////////////////////////////////////
	task summarize();
		$display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task chk(input logic [13:0] got, input logic [13:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_in);
		reg_addr_in  <= a;
		reg_wdata_in <= d;
		reg_wr_in    <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask

	task rdchk(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in   <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1;
		chk({6'h00, reg_rdata_out}, {6'h00, e});
	endtask

	task load(input flash_seq_pkg::addr_t a, input flash_seq_pkg::word_t d);
		wr(3'h2, a[7:0]);
		wr(3'h3, {4'h0, a[11:8]});
		wr(3'h4, d[7:0]);
		wr(3'h5, {2'h0, d[13:8]});
	endtask

	task trig();
		wr(3'h1, 8'h55);
		wr(3'h1, 8'hAA);
		wr(3'h0, 8'h06);
	endtask

	task clr();
		@(negedge clk_in);
		n_er = 0;
		n_pr = 0;
		n_halt = 0;
		n_rd = 0;
	endtask

	// waits past the preparation cycles, then until the halt has dropped
	task settle();
		int i;
		for (i = 0; i < 300; i++) begin
			@(posedge clk_in);
			#1;
			if (i >= 8 && cpu_halt_during_access_out === 1'b0) break;
		end
		if (i >= 300) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, 1'b1, 1'b0);
			summarize();
		end
	endtask

	task quiet();
		chk(n_pr, 0);
		chk(n_er, 0);
		chk(n_halt, 0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task t_reset();
		rdchk(3'h0, 8'h00);
		rdchk(3'h4, 8'h00);
		rdchk(3'h6, 8'h00);
		chk(cpu_halt_during_access_out, 1'b0);
		$display("reset test done");
	endtask

	task t_pwrt();
		clr();
		wr(3'h0, 8'h04);
		load(12'h303, 14'h1234);
		trig();
		settle();
		quiet();
		rdchk(3'h0, 8'h04);
		repeat (PWRT) @(posedge clk_in);
		$display("power-up timer test done");
	endtask

	task t_read();
		clr();
		load(12'h5A7, 14'h0000);
		wr(3'h0, 8'h05);
		rdchk(3'h4, 8'(pat(12'h5A7)));
		rdchk(3'h5, 8'(pat(12'h5A7) >> 8));
		rdchk(3'h0, 8'h04);
		chk(n_rd, 1);
		chk(rd_a, 12'h5A7);
		$display("read test done");
	endtask

	task t_group(input flash_seq_pkg::addr_t base, input int erase);
		for (int i = 0; i < 4; i++) begin
			clr();
			load(base + 12'(i), {2'h1, base + 12'(i)});
			// unchanged slot refilled by a read
			if (erase == 0 && i == 1) wr(3'h0, 8'h05);
			trig();
			if (i < 3) begin
				settle();
				quiet();
				rdchk(3'h0, 8'h04);
			end
		end
		// bus left quiet while the commit is prepared
		repeat (3) @(posedge clk_in);
		wr(3'h0, 8'h04);
		rdchk(3'h0, 8'h06);
		settle();
		chk(n_er, erase);
		if (erase == 1) chk(er_a, base);
		chk(n_pr, 4);
		for (int i = 0; i < 4; i++) begin
			chk(pr_a[i], base + 12'(i));
			if (erase == 0 && i == 1) chk(pr_d[i], pat(base + 12'(i)));
			else chk(pr_d[i], {2'h1, base + 12'(i)});
		end
		chk(n_halt, STALL);
		rdchk(3'h0, 8'h04);
		$display("group test done");
	endtask

	task t_ignore();
		clr();
		load(12'h203, 14'h0777);
		wr(3'h1, 8'hAA);
		wr(3'h0, 8'h06);
		settle();
		wr(3'h1, 8'h55);
		wr(3'h1, 8'hAA);
		wr(3'h4, 8'h77);
		wr(3'h0, 8'h06);
		settle();
		wr(3'h0, 8'h00);
		wr(3'h1, 8'h55);
		wr(3'h1, 8'hAA);
		wr(3'h0, 8'h02);
		settle();
		quiet();
		rdchk(3'h0, 8'h00);
		wr(3'h0, 8'h04);
		$display("ignored trigger test done");
	endtask

	task t_protect();
		write_protect_field_in <= 2'b10;
		repeat (4) @(posedge clk_in);
		clr();
		load(12'h0F3, 14'h0111);
		trig();
		settle();
		quiet();
		wr(3'h0, 8'h05);
		rdchk(3'h4, 8'(pat(12'h0F3)));
		write_protect_field_in <= 2'b11;
		repeat (4) @(posedge clk_in);
		$display("write protect test done");
	endtask

	task t_codeprot();
		ext_prog_write_in      <= 1'b1;
		write_protect_field_in <= 2'b00;
		repeat (4) @(posedge clk_in);
		chk(ext_prog_allow_out, 1'b1);
		code_protect_in <= 1'b1;
		wr(3'h0, 8'h44);
		repeat (4) @(posedge clk_in);
		chk(ext_prog_allow_out, 1'b0);
		chk(flash_test_sel_out, 1'b0);
		code_protect_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		chk(flash_test_sel_out, 1'b1);
		ext_prog_write_in      <= 1'b0;
		write_protect_field_in <= 2'b11;
		wr(3'h0, 8'h04);
		$display("code protect test done");
	endtask

	// a write while the clock enable is low must leave the register untouched
	task t_freeze();
		ce_in <= 1'b0;
		wr(3'h2, 8'h3C);
		ce_in <= 1'b1;
		rdchk(3'h2, 8'hF3);
		$display("clock enable test done");
	endtask

	initial begin
		resetn_in = 1'b0;
		ce_in = 1'b1;
		reg_addr_in = 3'h0;
		reg_wdata_in = 8'h00;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		write_protect_field_in = 2'b11;
		code_protect_in = 1'b0;
		ext_prog_write_in = 1'b0;
		n_mismatch = 0;
		tests_run = 0;
		repeat (20) @(posedge clk_in);
		resetn_in <= 1'b1;
		t_reset();
		t_pwrt();
		t_read();
		t_group(12'h100, 1);
		t_group(12'h104, 0);
		t_group(12'h108, 0);
		t_group(12'h10C, 0);
		t_ignore();
		t_protect();
		t_codeprot();
		t_freeze();
		summarize();
	end
endmodule
